// ---- hdl/flash_front.sv ----
// Overview of operation
// - Deep sleep ignores all but wake opcode
// - Whole bytes after wake opcode are discarded
// - Valid wake frame returns to standby
// - Short or misaligned wake frame ignored
// - Pause never stops timed array cycles
// - Pause only while chip select asserted
// - Pause begins in clock low phase
// - Paused while pause and select held
// - Paused: output floats, clock and data ignored
// - Write protect stays live during pause
// - Pause ends in clock low phase
// - Deselect while paused aborts, clears latch
// - Sleep opcode on byte boundary sleeps unless BUSY_IN high
// - Wake delay at most thirty microseconds
// - Power-up starts in standby
`timescale 1ns/1ns
`default_nettype none
module flash_front
	import flash_front_pkg::*;
#(
	parameter int WAKE_CYCLES  = WAKE_DELAY_CYC,
	parameter int SLEEP_CYCLES = SLEEP_ENTRY_CYC
) (
	// Clock and reset
	input  wire logic CLK,
	input  wire logic SYS_RST,
	// Serial pins
	input  wire logic CS_N,
	input  wire logic SCK,
	input  wire logic SI,
	input  wire logic PAUSE_N,
	input  wire logic WP_N,
	output logic      SO_O,
	output logic      SO_OE,
	// Array side
	input  wire logic BUSY_IN,
	input  wire logic WEL_SET,
	output logic      WRITE_ENABLE_LATCH,
	output logic      SLEEPING,
	output logic      READY,
	output logic      PAUSED,
	output logic      WP_ACTIVE,
	output logic      CMD_VALID,
	output logic [7:0] CMD_BYTE,
	output logic      ABORT
);

	// Refuse counts the delay counters cannot serve
	if (WAKE_CYCLES < 1 || WAKE_CYCLES > WAKE_DELAY_CYC) begin : g_bad_wake
		$error("WAKE_CYCLES out of range");
	end
	if (SLEEP_CYCLES < 1) begin : g_bad_sleep
		$error("SLEEP_CYCLES out of range");
	end

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	localparam pins_type PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
		pause_n: 1'b1, wp_n: 1'b1};

	pins_type raw;
	pins_type pin;

	assign raw = '{cs_n: CS_N, sck: SCK, si: SI, pause_n: PAUSE_N,
		wp_n: WP_N};

	pin_sync #(
		.RESET_VAL (PIN_IDLE)
	) u_sync (
		.clk      (CLK),
		.rst      (SYS_RST),
		.pins_in  (raw),
		.pins_out (pin)
	);

	// ****************************************************************
	// Shift and pause state
	// ****************************************************************
	localparam int CW = $clog2(WAKE_CYCLES + SLEEP_CYCLES + 1);

	logic           sck_d_r,   sck_d_nxt;
	logic           cs_d_r,    cs_d_nxt;
	logic           pause_r,   pause_nxt;
	logic [7:0]     shift_r,   shift_nxt;
	logic [2:0]     bitc_r,    bitc_nxt;
	logic           first_r,   first_nxt;
	logic           gotb_r,    gotb_nxt;
	logic [7:0]     opc_r,     opc_nxt;
	power_mode_type mode_r,    mode_nxt;
	logic [CW-1:0]  cnt_r,     cnt_nxt;
	logic           sleep_p_r, sleep_p_nxt;
	logic           wel_r,     wel_nxt;
	logic           valid_nxt, abort_nxt;
	logic [7:0]     byte_nxt;
	logic           rise, fall, cs_on, cs_rel, aligned;
	logic [7:0]     done_byte;

	always_comb begin
		rise      = pin.sck & ~sck_d_r;
		fall      = ~pin.sck & sck_d_r;
		cs_on     = ~pin.cs_n;
		cs_rel    = pin.cs_n & ~cs_d_r;
		done_byte = {shift_r[6:0], pin.si};
		aligned   = (bitc_r == 3'h0);
		sck_d_nxt = pin.sck;
		cs_d_nxt  = pin.cs_n;
		pause_nxt = pause_r;
		shift_nxt = shift_r;
		bitc_nxt  = bitc_r;
		first_nxt = first_r;
		gotb_nxt  = gotb_r;
		opc_nxt   = opc_r;
		mode_nxt  = mode_r;
		cnt_nxt   = cnt_r;
		sleep_p_nxt = sleep_p_r;
		wel_nxt   = wel_r | (WEL_SET & mode_r == MODE_STANDBY);
		valid_nxt = 1'b0;
		abort_nxt = 1'b0;
		byte_nxt  = CMD_BYTE;
		// Pause follows the pin only in clock low phase with select held; deselect clears it
		if (!cs_on)
			pause_nxt = 1'b0;
		else if (!pin.sck)
			pause_nxt = ~pin.pause_n;
		// Frame shift, frozen while paused
		if (cs_on && rise && !pause_r) begin
			shift_nxt = done_byte;
			bitc_nxt  = bitc_r + 3'h1;
			if (bitc_r == 3'(BYTE_BITS - 1)) begin
				first_nxt = 1'b0;
				if (first_r) begin
					gotb_nxt = 1'b1;
					opc_nxt  = done_byte;
				end
				if (mode_r == MODE_STANDBY) begin
					valid_nxt = 1'b1;
					byte_nxt  = done_byte;
				end
			end
		end
		// End of frame
		if (cs_rel) begin
			if (pause_r) begin
				abort_nxt = 1'b1;
				wel_nxt   = 1'b0;
			end else if (gotb_r && aligned) begin
				if (mode_r == MODE_SLEEP && opc_r == OPC_WAKE) begin
					mode_nxt = MODE_WAKING;
					cnt_nxt  = CW'(WAKE_CYCLES);
				end else if (mode_r == MODE_STANDBY &&
					opc_r == OPC_SLEEP && !BUSY_IN) begin
					sleep_p_nxt = 1'b1;
					cnt_nxt     = CW'(SLEEP_CYCLES);
				end
			end else if (gotb_r && mode_r == MODE_STANDBY) begin
				abort_nxt = 1'b1;
				wel_nxt   = 1'b0;
			end
			bitc_nxt  = 3'h0;
			first_nxt = 1'b1;
			gotb_nxt  = 1'b0;
		end else if (!cs_on) begin
			bitc_nxt  = 3'h0;
			first_nxt = 1'b1;
			gotb_nxt  = 1'b0;
		end
		// Delay counters
		unique case (mode_r)
			MODE_WAKING: begin
				if (cnt_r <= CW'(1)) begin
					mode_nxt = MODE_STANDBY;
					cnt_nxt  = '0;
				end else
					cnt_nxt = cnt_r - CW'(1);
			end
			MODE_STANDBY: begin
				if (sleep_p_r) begin
					if (cnt_r <= CW'(1)) begin
						mode_nxt    = MODE_SLEEP;
						sleep_p_nxt = 1'b0;
						cnt_nxt     = '0;
					end else
						cnt_nxt = cnt_r - CW'(1);
				end
			end
			MODE_SLEEP: begin
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sck_d_r   <= 1'b0;
			cs_d_r    <= 1'b1;
			pause_r   <= 1'b0;
			shift_r   <= 8'h00;
			bitc_r    <= 3'h0;
			first_r   <= 1'b1;
			gotb_r    <= 1'b0;
			opc_r     <= 8'h00;
			mode_r    <= MODE_STANDBY;
			cnt_r     <= '0;
			sleep_p_r <= 1'b0;
			wel_r     <= 1'b0;
		end else begin
			sck_d_r   <= sck_d_nxt;
			cs_d_r    <= cs_d_nxt;
			pause_r   <= pause_nxt;
			shift_r   <= shift_nxt;
			bitc_r    <= bitc_nxt;
			first_r   <= first_nxt;
			gotb_r    <= gotb_nxt;
			opc_r     <= opc_nxt;
			mode_r    <= mode_nxt;
			cnt_r     <= cnt_nxt;
			sleep_p_r <= sleep_p_nxt;
			wel_r     <= wel_nxt;
		end
	end

	// ****************************************************************
	// Output registers
	// ****************************************************************
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SO_O               <= 1'b0;
			SO_OE              <= 1'b0;
			WRITE_ENABLE_LATCH <= 1'b0;
			SLEEPING           <= 1'b0;
			READY              <= 1'b1;
			PAUSED             <= 1'b0;
			WP_ACTIVE          <= 1'b0;
			CMD_VALID          <= 1'b0;
			CMD_BYTE           <= 8'h00;
			ABORT              <= 1'b0;
		end else begin
			SO_O               <= 1'b0;
			SO_OE              <= 1'b0;
			WRITE_ENABLE_LATCH <= wel_nxt;
			SLEEPING           <= (mode_nxt != MODE_STANDBY);
			READY              <= (mode_nxt == MODE_STANDBY);
			PAUSED             <= pause_nxt;
			WP_ACTIVE          <= ~pin.wp_n;
			CMD_VALID          <= valid_nxt;
			CMD_BYTE           <= byte_nxt;
			ABORT              <= abort_nxt;
		end
	end
	// BUSY_IN is never gated by pause, so timed cycles run on

	// ****************************************************************
	// Wake age counter for checks
	// ****************************************************************
	localparam int AW = $clog2(WAKE_CYCLES + 1);

	logic [AW-1:0]  wake_age_r, wake_age_nxt;

	always_comb begin
		wake_age_nxt = '0;
		if (mode_r == MODE_WAKING && wake_age_r != '1)
			wake_age_nxt = wake_age_r + AW'(1);
		else if (mode_r == MODE_WAKING)
			wake_age_nxt = wake_age_r;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST)
			wake_age_r <= '0;
		else
			wake_age_r <= wake_age_nxt;
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_sleep_ignores: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_r != MODE_STANDBY |=> !CMD_VALID)
		else $error("command accepted while not in standby");
	a_pause_needs_cs: assert property (@(posedge CLK) disable iff (SYS_RST)
		pin.cs_n |=> !pause_r)
		else $error("pause held without chip select");
	a_pause_high_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
		pin.sck && !pin.cs_n |=> pause_r == $past(pause_r))
		else $error("pause changed in clock high phase");
	a_pause_frozen: assert property (@(posedge CLK) disable iff (SYS_RST)
		pause_r && !pin.cs_n |=> bitc_r == $past(bitc_r))
		else $error("shift advanced while paused");
	a_wake_bound: assert property (@(posedge CLK) disable iff (SYS_RST)
		mode_r == MODE_WAKING |-> wake_age_r < AW'(WAKE_CYCLES))
		else $error("wake delay exceeded");
	a_bad_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
		cs_rel && mode_r == MODE_SLEEP && !aligned |=> mode_r == MODE_SLEEP)
		else $error("misaligned wake left sleep");
	a_abort_wel: assert property (@(posedge CLK) disable iff (SYS_RST)
		cs_rel && pause_r |=> !wel_r ##0 ABORT)
		else $error("deselect while paused did not clear latch");
	a_so_float: assert property (@(posedge CLK) disable iff (SYS_RST)
		PAUSED |-> !SO_OE)
		else $error("output driven while paused");

endmodule
`default_nettype wire

// ---- hdl/flash_front_pkg.sv ----
package flash_front_pkg;

	// ****************************************************************
	// Opcodes and framing
	// ****************************************************************
	localparam logic [7:0] OPC_WAKE    = 8'hAB;
	localparam logic [7:0] OPC_SLEEP   = 8'hB9;
	localparam int         BYTE_BITS   = 8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS       = 4;
	localparam int WAKE_DELAY_US       = 30;
	localparam int WAKE_DELAY_CYC      = (WAKE_DELAY_US * 1000) / CLK_PERIOD_NS;
	localparam int SLEEP_ENTRY_US      = 3;
	localparam int SLEEP_ENTRY_CYC     = (SLEEP_ENTRY_US * 1000) / CLK_PERIOD_NS;

	// ****************************************************************
	// Power modes
	// ****************************************************************
	typedef enum logic [2:0] {
		MODE_STANDBY = 3'b001,
		MODE_SLEEP   = 3'b010,
		MODE_WAKING  = 3'b100
	} power_mode_type;

	// ****************************************************************
	// Synchronised pin bundle
	// ****************************************************************
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic pause_n;
		logic wp_n;
	} pins_type;

endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_sync
	import flash_front_pkg::*;
#(
	parameter pins_type RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic     clk,
	input  wire logic     rst,
	// Pins
	input  wire pins_type pins_in,
	output var  pins_type pins_out
);

	pins_type stage_r;
	pins_type stage_nxt;
	pins_type out_nxt;

	always_comb begin
		stage_nxt = pins_in;
		out_nxt   = stage_r;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stage_r  <= RESET_VAL;
			pins_out <= RESET_VAL;
		end else begin
			stage_r  <= stage_nxt;
			pins_out <= out_nxt;
		end
	end

endmodule
`default_nettype wire

// ---- verification/spi_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	// Clock
	input  wire logic clk,
	// Host pins
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      pause_n,
	output logic      wp_n
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		pause_n = 1'b1;
		wp_n = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic sck_to(input logic v);
		sck = v;
		w(20);
	endtask
	// One data bit, clock left high
	task automatic rise_only(input logic d);
		si = d;
		sck_to(1'b1);
	endtask
	// Pause pin moved, clock left in whatever phase it is
	task automatic pz(input logic on);
		pause_n = !on;
		w(8);
	endtask
	task automatic wp(input logic v);
		wp_n = v;
		w(8);
	endtask
	// Released data line shows the inverse
	task automatic sel(input logic on);
		cs_n = !on;
		if (!on) si = !si;
		w(on ? 20 : 1);
	endtask
	// MSB first, clock idles low
	task automatic shift(input logic [15:0] d, input int n);
		for (int i = 0; i < n; i++) begin
			si = d[15 - i];
			sck_to(1'b1);
			sck_to(1'b0);
		end
	endtask
endmodule
`default_nettype wire

// ---- verification/tb_flash_front.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_flash_front
	import flash_front_pkg::*;
;
	localparam int WAKE_T  = 20;
	localparam int SLEEP_T = 10;
	logic        CLK;
	logic        SYS_RST;
	logic        BUSY_IN;
	logic        WEL_SET;
	wire  logic  CS_N;
	wire  logic  SCK;
	wire  logic  SI;
	wire  logic  PAUSE_N;
	wire  logic  WP_N;
	logic        SO_O;
	logic        SO_OE;
	logic        WRITE_ENABLE_LATCH;
	logic        SLEEPING;
	logic        READY;
	logic        PAUSED;
	logic        WP_ACTIVE;
	logic        CMD_VALID;
	logic        ABORT;
	logic [7:0]  CMD_BYTE;
	logic [7:0]  last_cmd;
	logic [7:0]  b;
	logic [7:0]  n;
	logic [31:0] seed = 32'h0000_3026;
	int          error_cnt;
	int          n_checks;
	int          cmd_cnt;
	int          abort_cnt;
	int          cyc;

	spi_host_model host (
		.clk     (CLK),
		.cs_n    (CS_N),
		.sck     (SCK),
		.si      (SI),
		.pause_n (PAUSE_N),
		.wp_n    (WP_N)
	);
	flash_front #(
		.WAKE_CYCLES  (WAKE_T),
		.SLEEP_CYCLES (SLEEP_T)
	) DUT (
		.CLK                (CLK),
		.SYS_RST            (SYS_RST),
		.CS_N               (CS_N),
		.SCK                (SCK),
		.SI                 (SI),
		.PAUSE_N            (PAUSE_N),
		.WP_N               (WP_N),
		.SO_O               (SO_O),
		.SO_OE              (SO_OE),
		.BUSY_IN            (BUSY_IN),
		.WEL_SET            (WEL_SET),
		.WRITE_ENABLE_LATCH (WRITE_ENABLE_LATCH),
		.SLEEPING           (SLEEPING),
		.READY              (READY),
		.PAUSED             (PAUSED),
		.WP_ACTIVE          (WP_ACTIVE),
		.CMD_VALID          (CMD_VALID),
		.CMD_BYTE           (CMD_BYTE),
		.ABORT              (ABORT)
	);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task automatic frame(input logic [15:0] d, input int nb);
		host.sel(1'b1);
		host.shift(d, nb);
		host.sel(1'b0);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (!SYS_RST && CMD_VALID === 1'b1) begin
			cmd_cnt++;
			last_cmd = CMD_BYTE;
		end
		if (!SYS_RST && ABORT === 1'b1) abort_cnt++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		SYS_RST = 1'b1;
		BUSY_IN = 1'b0;
		WEL_SET = 1'b0;
		repeat (6) @(posedge CLK);
		#1 SYS_RST = 1'b0;
		host.w(3);
		chk("ready", 8'h01, READY);
		chk("sleeping", 8'h00, SLEEPING);
		for (int i = 0; i < 4; i++) begin
			b = i == 0 ? 8'h00 : i == 1 ? 8'hFF : rnd();
			if (b == OPC_SLEEP) b = 8'h00;
			frame({b, 8'h00}, 8);
			host.w(5);
			chk("cmd", b, last_cmd);
		end
		BUSY_IN = 1'b1;
		frame({OPC_SLEEP, 8'h00}, 8);
		host.w(25);
		BUSY_IN = 1'b0;
		chk("ready busy", 8'h01, READY);
		frame({OPC_SLEEP, rnd()}, 16);
		host.w(25);
		chk("sleep", 8'h01, SLEEPING);
		n = cmd_cnt[7:0];
		b = rnd();
		if (b == OPC_WAKE) b = 8'h05;
		frame({b, 8'h00}, 8);
		frame({OPC_WAKE, 8'h00}, 5);
		frame({OPC_WAKE, 8'hFF}, 11);
		host.w(40);
		chk("sleep held", 8'h01, SLEEPING);
		chk("no cmd", n, cmd_cnt[7:0]);
		chk("no abort", 8'h00, abort_cnt[7:0]);
		frame({OPC_WAKE, rnd()}, 16);
		host.w(7);
		chk("waking", 8'h00, READY);
		host.w(25);
		chk("woken", 8'h01, READY);
		b = rnd();
		if (b == OPC_SLEEP) b = 8'h00;
		host.sel(1'b1);
		host.shift({b, 8'h00}, 3);
		host.rise_only(b[4]);
		host.pz(1'b1);
		chk("pause high", 8'h00, PAUSED);
		host.sck_to(1'b0);
		chk("paused", 8'h01, PAUSED);
		host.shift({rnd(), 8'h00}, 3);
		host.wp(1'b0);
		chk("wp", 8'h01, WP_ACTIVE);
		chk("so float", 8'h00, SO_OE);
		chk("so data", 8'h00, SO_O);
		chk("paused held", 8'h01, PAUSED);
		host.wp(1'b1);
		host.pz(1'b0);
		chk("unpaused", 8'h00, PAUSED);
		host.shift({b[3:0], 12'h000}, 4);
		host.sel(1'b0);
		host.w(5);
		chk("cmd pause", b, last_cmd);
		WEL_SET = 1'b1;
		host.w(1);
		WEL_SET = 1'b0;
		host.w(3);
		chk("wel set", 8'h01, WRITE_ENABLE_LATCH);
		n = abort_cnt[7:0] + 8'h01;
		host.sel(1'b1);
		host.shift({rnd(), 8'h00}, 2);
		host.pz(1'b1);
		host.sel(1'b0);
		host.w(8);
		chk("wel clr", 8'h00, WRITE_ENABLE_LATCH);
		chk("abort", n, abort_cnt[7:0]);
		host.pz(1'b0);
		host.pz(1'b1);
		chk("no sel pause", 8'h00, PAUSED);
		host.pz(1'b0);
		WEL_SET = 1'b1;
		host.w(1);
		WEL_SET = 1'b0;
		host.w(3);
		n = abort_cnt[7:0] + 8'h01;
		frame({rnd(), 8'h00}, 12);
		host.w(8);
		chk("misaligned abort", n, abort_cnt[7:0]);
		chk("misaligned wel", 8'h00, WRITE_ENABLE_LATCH);
		end_of_test();
	end
endmodule
`default_nettype wire
